//--- pkg/iox_pkg.sv
// Constants and types shared by the I/O expander bus slave and its FIFO.
package iox_pkg;

    // ------------------------------------------------------------------
    // Register indices selected by the command byte
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_IN0 = 3'h0;
    localparam logic [2:0] REG_IN1 = 3'h1;
    localparam logic [2:0] REG_OUT0 = 3'h2;
    localparam logic [2:0] REG_OUT1 = 3'h3;
    localparam logic [2:0] REG_POL0 = 3'h4;
    localparam logic [2:0] REG_POL1 = 3'h5;
    localparam logic [2:0] REG_CFG0 = 3'h6;
    localparam logic [2:0] REG_CFG1 = 3'h7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] OUT_RST = 16'hFFFF;
    localparam logic [15:0] POL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'hFFFF;

    // ------------------------------------------------------------------
    // Bus address, field layout and sizes
    // ------------------------------------------------------------------
    // The fixed upper address bits are an arbitrary value.
    localparam logic [3:0] ADDR_HI = 4'h4;
    localparam int PORT_W = 16;
    localparam int BYTE_W = 8;
    localparam int PTR_W = 3;
    localparam int FIFO_W = PTR_W + BYTE_W;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_W = 2 + 3 + PORT_W;
    localparam logic [1:0] INIT_DONE = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WR,
        ST_SACK,
        ST_RD,
        ST_MACK
    } iox_state_type;

endpackage : iox_pkg

//--- rtl/iox_fifo.sv
// Small FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module iox_fifo #(
    parameter int WIDTH = iox_pkg::FIFO_W,
    parameter int DEPTH = iox_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : iox_fifo

//--- rtl/iox_i2c_slave.sv
// Two-wire bus slave, port registers and change interrupt of the expander.
//
// Summary of operation
// R1 - Input pin level change raises interrupt.
// R2 - Pin returning to old level withdraws it.
// R3 - Reading input register withdraws its interrupt.
// R4 - Output pins never raise an interrupt.
// R5 - Each port's read clears only its own.
// R6 - Output-to-input switch may raise false interrupt.
// R7 - Master starts only while bus idle.
// R8 - One bit per clock, data stable high.
// R9 - Data change while clock high is control.
// R10 - Both lines released high when idle.
// R11 - Data falling while clock high is START.
// R12 - Data rising while clock high is STOP.
// R13 - Unlimited data bytes per transfer.
// R14 - One acknowledge clock after every byte.
// R15 - Acknowledge every received byte when addressed.
// R16 - Master acknowledges all but last read.
// R17 - Acknowledger holds data low whole high.
// R18 - Master ends read with no acknowledge.
// R19 - Release data line after missing acknowledge.
// R20 - Write: address with zero, then command.
// R21 - Successive bytes alternate within register pair.
// R22 - Direction bit one means input, zero output.
// R23 - Interrupt pin low while anything pending.
`timescale 1ns/1ps
module iox_i2c_slave (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] addr_i,
    input wire logic [15:0] io_i,
    output logic [15:0] io_o,
    output logic [15:0] io_oe,
    output logic int_o,
    output logic int_oe
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    default clocking cb_sys @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic [iox_pkg::SYNC_W-1:0] sync1_q;
    logic [iox_pkg::SYNC_W-1:0] sync2_q;
    logic scl_s;
    logic sda_s;
    logic [2:0] addr_s;
    logic [15:0] pins;
    logic scl_p_q;
    logic sda_p_q;
    logic rise;
    logic fall;
    logic start_det;
    logic stop_det;
    iox_pkg::iox_state_type state_q;
    iox_pkg::iox_state_type nxt_q;
    logic [2:0] cnt_q;
    logic done_q;
    logic [7:0] shift_q;
    logic [2:0] ptr_q;
    logic ack_q;
    logic sda_oe_q;
    logic low_q;
    logic [15:0] out_q;
    logic [15:0] pol_q;
    logic [15:0] cfg_q;
    logic [15:0] snap_q;
    logic [1:0] init_q;
    logic [15:0] pend;
    logic [15:0] in_val;
    logic [7:0] rd_byte;
    logic load;
    logic push_req;
    logic push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [iox_pkg::FIFO_W-1:0] fifo_out_data;
    logic drain_ready;
    logic pop;
    logic [15:0] io_o_q;
    logic [15:0] io_oe_q;
    logic int_oe_q;

    // ------------------------------------------------------------------
    // Input synchronisers and line edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= {scl_i, sda_i, addr_i, io_i};
            sync2_q <= sync1_q;
        end
    end

    assign scl_s = sync2_q[iox_pkg::SYNC_W-1];
    assign sda_s = sync2_q[iox_pkg::SYNC_W-2];
    assign addr_s = sync2_q[iox_pkg::PORT_W+2:iox_pkg::PORT_W];
    assign pins = sync2_q[iox_pkg::PORT_W-1:0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign rise = scl_s && !scl_p_q;
    assign fall = !scl_s && scl_p_q;
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s; // see R11
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s; // see R12

    // ------------------------------------------------------------------
    // Register read selection
    // ------------------------------------------------------------------
    assign in_val = pins ^ pol_q;

    always_comb begin
        unique case (ptr_q)
            iox_pkg::REG_IN0: rd_byte = in_val[7:0];
            iox_pkg::REG_IN1: rd_byte = in_val[15:8];
            iox_pkg::REG_OUT0: rd_byte = out_q[7:0];
            iox_pkg::REG_OUT1: rd_byte = out_q[15:8];
            iox_pkg::REG_POL0: rd_byte = pol_q[7:0];
            iox_pkg::REG_POL1: rd_byte = pol_q[15:8];
            iox_pkg::REG_CFG0: rd_byte = cfg_q[7:0];
            iox_pkg::REG_CFG1: rd_byte = cfg_q[15:8];
        endcase
    end

    assign load = fall && (((state_q == iox_pkg::ST_SACK)
                  && (nxt_q == iox_pkg::ST_RD))
                  || ((state_q == iox_pkg::ST_MACK) && ack_q));
    assign push_req = fall && done_q && (state_q == iox_pkg::ST_WR);
    assign push = push_req && fifo_in_ready;

    // ------------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= iox_pkg::ST_IDLE;
            nxt_q <= iox_pkg::ST_IDLE;
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            shift_q <= 8'h00;
            ptr_q <= 3'h0;
            ack_q <= 1'b0;
            sda_oe_q <= 1'b0; // see R10
        end else if (start_det) begin
            state_q <= iox_pkg::ST_ADDR; // see R9
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= iox_pkg::ST_IDLE; // see R9
            done_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                iox_pkg::ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                iox_pkg::ST_ADDR, iox_pkg::ST_CMD, iox_pkg::ST_WR: begin
                    if (rise) begin
                        shift_q <= {shift_q[6:0], sda_s}; // see R8
                        cnt_q <= cnt_q + 3'h1;
                        done_q <= (cnt_q == iox_pkg::LAST_BIT);
                    end else if (fall && done_q) begin
                        done_q <= 1'b0;
                        if (state_q == iox_pkg::ST_ADDR) begin
                            if (shift_q[7:1] == {iox_pkg::ADDR_HI, addr_s})
                            begin
                                sda_oe_q <= 1'b1; // see R15
                                state_q <= iox_pkg::ST_SACK;
                                nxt_q <= shift_q[0] ? iox_pkg::ST_RD
                                                    : iox_pkg::ST_CMD; // see R20
                            end else begin
                                state_q <= iox_pkg::ST_IDLE;
                            end
                        end else if (state_q == iox_pkg::ST_CMD) begin
                            ptr_q <= shift_q[2:0];
                            sda_oe_q <= 1'b1; // see R15
                            state_q <= iox_pkg::ST_SACK;
                            nxt_q <= iox_pkg::ST_WR;
                        end else if (fifo_in_ready) begin
                            ptr_q[0] <= !ptr_q[0]; // see R21
                            sda_oe_q <= 1'b1; // see R13
                            state_q <= iox_pkg::ST_SACK;
                            nxt_q <= iox_pkg::ST_WR;
                        end else begin
                            state_q <= iox_pkg::ST_IDLE;
                        end
                    end
                end
                iox_pkg::ST_SACK: begin
                    if (fall) begin
                        state_q <= nxt_q; // see R14
                        cnt_q <= 3'h0;
                        if (nxt_q == iox_pkg::ST_RD) begin
                            shift_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                            ptr_q[0] <= !ptr_q[0]; // see R21
                        end else begin
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                iox_pkg::ST_RD: begin
                    if (fall) begin
                        if (cnt_q == iox_pkg::LAST_BIT) begin
                            sda_oe_q <= 1'b0; // see R14
                            state_q <= iox_pkg::ST_MACK;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                            shift_q <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= !shift_q[6]; // see R8
                        end
                    end
                end
                iox_pkg::ST_MACK: begin
                    if (rise) begin
                        ack_q <= !sda_s; // see R16
                    end else if (fall) begin
                        cnt_q <= 3'h0;
                        if (ack_q) begin
                            state_q <= iox_pkg::ST_RD;
                            shift_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                            ptr_q[0] <= !ptr_q[0]; // see R21
                        end else begin
                            state_q <= iox_pkg::ST_IDLE; // see R18
                            sda_oe_q <= 1'b0; // see R19
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Write data FIFO and register update
    // ------------------------------------------------------------------
    assign drain_ready = !load;
    assign pop = fifo_out_valid && drain_ready;

    iox_fifo #(
        .WIDTH(iox_pkg::FIFO_W),
        .DEPTH(iox_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push_req),
        .in_ready(fifo_in_ready),
        .in_data({ptr_q, shift_q}),
        .out_valid(fifo_out_valid),
        .out_ready(drain_ready),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= iox_pkg::OUT_RST;
            pol_q <= iox_pkg::POL_RST;
            cfg_q <= iox_pkg::CFG_RST;
        end else if (pop) begin
            unique case (fifo_out_data[iox_pkg::FIFO_W-1:iox_pkg::BYTE_W])
                iox_pkg::REG_IN0, iox_pkg::REG_IN1: begin
                end
                iox_pkg::REG_OUT0: out_q[7:0] <= fifo_out_data[7:0];
                iox_pkg::REG_OUT1: out_q[15:8] <= fifo_out_data[7:0];
                iox_pkg::REG_POL0: pol_q[7:0] <= fifo_out_data[7:0];
                iox_pkg::REG_POL1: pol_q[15:8] <= fifo_out_data[7:0];
                iox_pkg::REG_CFG0: cfg_q[7:0] <= fifo_out_data[7:0];
                iox_pkg::REG_CFG1: cfg_q[15:8] <= fifo_out_data[7:0];
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Input snapshot and change interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            snap_q <= 16'h0000;
            init_q <= 2'h0;
        end else if (init_q != iox_pkg::INIT_DONE) begin
            init_q <= init_q + 2'h1;
            snap_q <= pins;
        end else if (load) begin
            if (ptr_q == iox_pkg::REG_IN0) begin
                snap_q[7:0] <= pins[7:0]; // see R3
            end
            if (ptr_q == iox_pkg::REG_IN1) begin
                snap_q[15:8] <= pins[15:8]; // see R5
            end
        end
    end

    // A pin that differs from its snapshot and is an input is pending;
    // a newly made input that already differs is flagged too.
    assign pend = (pins ^ snap_q) & cfg_q; // see R1, see R2, see R4, see R6

    // ------------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_o_q <= iox_pkg::OUT_RST;
            io_oe_q <= ~iox_pkg::CFG_RST;
            int_oe_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            io_o_q <= out_q;
            io_oe_q <= ~cfg_q; // see R22
            int_oe_q <= (init_q == iox_pkg::INIT_DONE) && (|pend); // see R23
            low_q <= 1'b0;
        end
    end

    assign io_o = io_o_q;
    assign io_oe = io_oe_q;
    assign int_oe = int_oe_q;
    assign int_o = low_q;
    assign sda_o = low_q;
    assign sda_oe = sda_oe_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_int_follows_pend: assert property (##1 // see R23
        (int_oe_q == $past((init_q == iox_pkg::INIT_DONE) && (|pend))))
        else $error("interrupt pin does not follow pending changes");

    a_no_output_int: assert property (((pins ^ snap_q) & cfg_q) // see R4
        == 16'h0000 |=> !int_oe_q)
        else $error("output pins raised an interrupt");

    a_start_enters: assert property (start_det |=> // see R11
        (state_q == iox_pkg::ST_ADDR) && (cnt_q == 3'h0))
        else $error("start condition not recognised");

    a_stop_releases: assert property (stop_det |=> // see R12
        (state_q == iox_pkg::ST_IDLE) && !sda_oe_q)
        else $error("stop condition not recognised");

    a_sda_stable_high: assert property ( // see R8
        (scl_s && scl_p_q && !start_det && !stop_det) |=> $stable(sda_oe_q))
        else $error("data line changed while clock high");

    a_ack_held_low: assert property ( // see R17
        (state_q == iox_pkg::ST_SACK) |-> sda_oe_q)
        else $error("acknowledge not driven low");

    a_nack_release: assert property ( // see R19
        ((state_q == iox_pkg::ST_MACK) && fall && !ack_q && !start_det
         && !stop_det) |=> !sda_oe_q ##1 !sda_oe_q)
        else $error("data line not released after missing acknowledge");

    a_read_clears_own: assert property ( // see R5
        (load && (ptr_q == iox_pkg::REG_IN0) && (init_q == iox_pkg::INIT_DONE))
        |=> (snap_q[7:0] == $past(pins[7:0]))
            && (snap_q[15:8] == $past(snap_q[15:8])))
        else $error("input read cleared the wrong port");

    a_ptr_alternates: assert property ( // see R21
        (push && !start_det && !stop_det) |=> (ptr_q[0] != $past(ptr_q[0])))
        else $error("register pointer did not alternate");

    a_dir_follows_cfg: assert property (##1 // see R22
        (io_oe_q == ~$past(cfg_q)))
        else $error("pin direction does not follow configuration");

endmodule : iox_i2c_slave

//--- sim/iox_bus_master.sv
// Behavioural two-wire bus master that drives the expander.
`timescale 1ns/1ps
module iox_bus_master (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_rel,
    output logic rx_stb,
    output logic [7:0] rx_val
);
    // --------
    // Bus sequencing
    // --------
    initial begin
        scl = 1'h1;
        sda_rel = 1'h1;
        rx_stb = 1'h0;
        rx_val = 8'h00;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    task automatic start_cond();
        sda_rel <= 1'h1;
        wait_clk(4);
        scl <= 1'h1;
        wait_clk(4);
        sda_rel <= 1'h0;
        wait_clk(4);
        scl <= 1'h0;
        wait_clk(2);
    endtask : start_cond

    task automatic stop_cond();
        sda_rel <= 1'h0;
        wait_clk(4);
        scl <= 1'h1;
        wait_clk(4);
        sda_rel <= 1'h1;
        wait_clk(4);
    endtask : stop_cond

    task automatic clock_bit(input logic b, output logic s);
        sda_rel <= b;
        wait_clk(2);
        scl <= 1'h1;
        wait_clk(2);
        s = sda_line;
        wait_clk(2);
        scl <= 1'h0;
        wait_clk(2);
    endtask : clock_bit

    task automatic post(input logic [7:0] v);
        rx_val <= v;
        rx_stb <= 1'h1;
        wait_clk(1);
        rx_stb <= 1'h0;
    endtask : post

    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'h1, s);
        post({7'h00, s});
    endtask : send_byte

    task automatic recv_byte(input logic last);
        logic s;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'h1, s);
            v[i] = s;
        end
        clock_bit(last, s);
        post(v);
    endtask : recv_byte
endmodule : iox_bus_master

//--- sim/tb.sv
// Self-checking testbench of the expander bus slave and interrupt.
`timescale 1ns/1ps
module tb;
    logic clk;
    logic arst_n;
    logic [2:0] addr;
    logic [15:0] pins;
    logic scl;
    logic sda_rel;
    logic sda_o;
    logic sda_oe;
    logic [15:0] io_o;
    logic [15:0] io_oe;
    logic int_o;
    logic int_oe;
    logic rx_stb;
    logic [7:0] rx_val;
    logic [15:0] exp_q[$];
    logic [31:0] seed;
    logic [31:0] rnd;
    int fail_count;
    int checked;
    wire logic sda_line = sda_rel & ~(sda_oe & ~sda_o);

    iox_i2c_slave u_dut (.clk(clk), .arst_n(arst_n), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_i(addr),
        .io_i(pins), .io_o(io_o), .io_oe(io_oe), .int_o(int_o),
        .int_oe(int_oe));
    iox_bus_master u_mst (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_rel(sda_rel), .rx_stb(rx_stb), .rx_val(rx_val));

    initial clk = 1'h0;
    always #12.5 clk = ~clk;

    // --------
    // Checking
    // --------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        if (rx_stb === 1'h1) begin
            if (exp_q.size() == 0) begin
                check({8'h00, rx_val}, 16'hFFFF);
            end else begin
                check({8'h00, rx_val}, exp_q.pop_front());
            end
        end
    end

    task automatic int_chk(input logic e);
        repeat (6) @(posedge clk);
        check({15'h0000, int_oe}, {15'h0000, e});
    endtask : int_chk

    task automatic rst_chk();
        arst_n <= 1'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        repeat (6) begin
            @(posedge clk);
            check({15'h0000, int_oe}, 16'h0000);
        end
        repeat (2) @(posedge clk);
        check(io_o, iox_pkg::OUT_RST);
        check(io_oe, 16'h0000);
        check({15'h0000, int_o}, 16'h0000);
    endtask : rst_chk

    // --------
    // Transfers
    // --------
    task automatic wr_reg(input logic [2:0] cmd, input logic [7:0] b0,
                          input logic [7:0] b1);
        repeat (4) exp_q.push_back(16'h0000);
        u_mst.start_cond();
        u_mst.send_byte({iox_pkg::ADDR_HI, addr, 1'h0});
        u_mst.send_byte({5'h00, cmd});
        u_mst.send_byte(b0);
        u_mst.send_byte(b1);
        u_mst.stop_cond();
        repeat (4) @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] cmd, input logic [7:0] e0,
                          input logic two, input logic [7:0] e1);
        repeat (3) exp_q.push_back(16'h0000);
        exp_q.push_back({8'h00, e0});
        if (two) begin
            exp_q.push_back({8'h00, e1});
        end
        u_mst.start_cond();
        u_mst.send_byte({iox_pkg::ADDR_HI, addr, 1'h0});
        u_mst.send_byte({5'h00, cmd});
        u_mst.start_cond();
        u_mst.send_byte({iox_pkg::ADDR_HI, addr, 1'h1});
        if (two) begin
            u_mst.recv_byte(1'h0);
        end
        u_mst.recv_byte(1'h1);
        @(posedge clk);
        check({15'h0000, sda_oe}, 16'h0000);
        u_mst.stop_cond();
        repeat (4) @(posedge clk);
    endtask : rd_reg

    // --------
    // Main sequence
    // --------
    initial begin
        seed = 32'h33DD;
        fail_count = 0;
        checked = 0;
        arst_n = 1'h0;
        addr = 3'h5;
        rnd = $random(seed);
        pins = rnd[15:0];
        rst_chk();
        int_chk(1'h0);
        wr_reg(iox_pkg::REG_CFG0, 8'h0F, 8'hFF);
        check(io_oe, 16'h00F0);
        rnd = $random(seed);
        wr_reg(iox_pkg::REG_OUT1, rnd[7:0], rnd[15:8]);
        check(io_o, {rnd[7:0], rnd[15:8]});
        pins <= pins ^ 16'h0001;
        int_chk(1'h1);
        pins <= pins ^ 16'h0001;
        int_chk(1'h0);
        pins <= pins ^ 16'h0010;
        int_chk(1'h0);
        pins <= pins ^ 16'h0101;
        int_chk(1'h1);
        rd_reg(iox_pkg::REG_IN1, pins[15:8], 1'h0, 8'h00);
        int_chk(1'h1);
        rd_reg(iox_pkg::REG_IN0, pins[7:0], 1'h1, pins[15:8]);
        int_chk(1'h0);
        pins <= pins ^ 16'h0020;
        int_chk(1'h0);
        wr_reg(iox_pkg::REG_CFG0, 8'h2F, 8'hFF);
        int_chk(1'h1);
        exp_q.push_back(16'h0001);
        u_mst.start_cond();
        u_mst.send_byte({iox_pkg::ADDR_HI, ~addr, 1'h0});
        u_mst.stop_cond();
        repeat (4) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000);
        rst_chk();
        int_chk(1'h0);
        wr_reg(iox_pkg::REG_CFG1, 8'hFF, 8'h0F);
        check(io_oe, 16'h00F0);
        check(16'(exp_q.size()), 16'h0000);
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge clk);
        check(16'h0000, 16'h0001);
        complete_run();
    end
endmodule : tb
